// ---- pkg/osc_select_defines.vh ----
// Constants for the oscillator mode and clock select block
`ifndef OSC_SELECT_DEFINES_VH
`define OSC_SELECT_DEFINES_VH

// Oscillator configuration field codes
`define CFG_LP 4'h0
`define CFG_XT 4'h1
`define CFG_FXTAL 4'h2
`define CFG_RESCAP 4'h3
`define CFG_EXTCLK 4'h4
`define CFG_EXTCLK_IO 4'h5
`define CFG_FXTAL_MULT 4'h6
`define CFG_RESCAP_IO 4'h7
`define CFG_INT_DUAL_IO 4'h8
`define CFG_INT_CLKOUT 4'h9
`define CFG_EXTCLK_ALT 4'hc
`define CFG_RESCAP_ALT 4'hb

// Register byte addresses
`define ADDR_CONFIG 12'h000
`define ADDR_CONTROL 12'h004
`define ADDR_TUNING 12'h008
`define ADDR_STATUS 12'h00c

// Control register fields
`define CTL_FREQ_LSB 4
`define CTL_FREQ_MSB 6
`define CTL_RESET 32'h0000_0060
`define FREQ_RESET 3'h6
// Configuration register fields
`define CFG_CODE_MSB 3
`define FEAT_LSB 8
`define FEAT_MSB 11
// Tuning register fields, then configuration and feature reset values
`define TUN_LOWSRC_BIT 7
`define TUN_MULT_BIT 6
`define TUN_TRIM_MSB 4
`define TUN_RESET 8'h00
`define CFG_RESET 4'h7
`define FEAT_RESET 4'h0

// Internal frequency select codes
`define FREQ_31K 3'h0
`define FREQ_4M 3'h6
`define FREQ_8M 3'h7

// Clock source encodings reported in status
`define SRC_EXT 3'h0
`define SRC_MAIN 3'h1
`define SRC_POST 3'h2
`define SRC_LOWF 3'h3
`define SRC_DIV256 3'h4
`define SRC_MULT 3'h5

`define MULT_FACTOR 4
`define CLKOUT_DIV 4
`define LOWF_DIV 256

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ---- hdl/osc_mode_select.v ----
// Oscillator mode decode, clock source select and pin function control
//
// How it works
// (RQ1) External clock modes request no start-up delay after reset or wake.
// (RQ2) External clock mode drives core clock divided by four on clock out.
// (RQ3) External clock I/O mode frees clock out as port A bit six.
// (RQ4) Resistor-capacitor mode drives core clock divided by four on clock out.
// (RQ5) Resistor-capacitor I/O mode frees clock out as port A bit six.
// (RQ6) Crystal multiplied mode runs crystal through times-four multiplier.
// (RQ7) In crystal multiplied mode the software multiplier bit is unavailable.
// (RQ8) Multiplier reaches crystal only for configuration code 0110.
// (RQ9) With internal block primary, software may enable the multiplier.
// (RQ10) Main internal oscillator drives core directly or through postscaler.
// (RQ11) Main oscillator on for 125k to 8M; at 31k per low source bit.
// (RQ12) Low-frequency oscillator runs whenever selected as device clock.
// (RQ13) Low-frequency oscillator runs when timer, monitor, watchdog or two-speed on.
// (RQ14) Frequency select field chooses main, low-frequency or postscaler output.
// (RQ15) Internal clock-out mode: clock out is Fosc/4, clock in is port A bit seven; the block drives ext_clk_in divided by four instead.
// (RQ16) Internal dual I/O mode: both oscillator pins are port A I/O.
// (RQ17) Crystal mode may be driven by an external clock on clock in.
// (RQ18) Codes 1001 and 1000 select the internal block as primary clock.
// (RQ19) Multiplier runs only at select 111 or 110; else bit stays clear.
// (RQ20) Low source bit set derives 31.25k from main divided by 256.
// (RQ21) Internal multiplier gives 16 or 32 MHz per selected input.
// (RQ22) Configuration field decodes into exactly one of ten modes.
// (RQ23) Port A bits six and seven are off while their pins carry clock.
`timescale 1ns/1ps
`include "osc_select_defines.vh"

module osc_mode_select (
    input wire sys_clk,
    input wire rst,
    input wire [11:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [11:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire ext_clk_in,
    input wire port_a_bit_six_in,
    input wire port_a_bit_seven_in,
    output reg clock_out_pin_o,
    output reg clock_out_pin_oe,
    output reg [3:0] core_src_sel_ff,
    output reg main_osc_en_ff,
    output reg lowf_osc_en_ff,
    output reg xtal_mult_en_ff,
    output reg int_mult_en_ff,
    output reg startup_delay_en_ff,
    output reg port_a_bit_six_en_ff,
    output reg port_a_bit_seven_en_ff,
    output reg port_a_bit_six_sync_ff,
    output reg port_a_bit_seven_sync_ff
);

    // Mode indices; mode_ff holds one of these as a binary code
    localparam M_LP = 4'h0;
    localparam M_XT = 4'h1;
    localparam M_FXTAL = 4'h2;
    localparam M_HSM = 4'h3;
    localparam M_RESCAP = 4'h4;
    localparam M_RESCAP_IO = 4'h5;
    localparam M_INT1 = 4'h6;
    localparam M_INT2 = 4'h7;
    localparam M_EXTCLK = 4'h8;
    localparam M_EXTCLK_IO = 4'h9;

    // Configuration code to one of ten modes
    function [3:0] decode_mode;
        input [3:0] code;
        begin
            case (code)
                `CFG_LP: decode_mode = M_LP;
                `CFG_XT: decode_mode = M_XT;
                `CFG_FXTAL: decode_mode = M_FXTAL;
                `CFG_FXTAL_MULT: decode_mode = M_HSM; // RQ8
                `CFG_RESCAP, `CFG_RESCAP_ALT: decode_mode = M_RESCAP;
                `CFG_RESCAP_IO: decode_mode = M_RESCAP_IO;
                `CFG_INT_CLKOUT: decode_mode = M_INT1; // RQ18
                `CFG_INT_DUAL_IO: decode_mode = M_INT2; // RQ18
                `CFG_EXTCLK, `CFG_EXTCLK_ALT: decode_mode = M_EXTCLK;
                `CFG_EXTCLK_IO: decode_mode = M_EXTCLK_IO;
                // Spare codes fall back to an external clock mode
                default: decode_mode = M_EXTCLK; // RQ22
            endcase
        end
    endfunction

    reg [3:0] cfg_ff;
    reg [3:0] feature_en_ff;
    reg [2:0] freq_sel_ff;
    reg lowf_src_ff;
    reg mult_bit_ff;
    reg [4:0] trim_ff;
    reg [3:0] mode_ff;
    reg [1:0] clk_sync_ff;
    reg clk_prev_ff;
    reg [1:0] quarter_ff;
    reg [1:0] pa6_meta_ff;
    reg [1:0] pa7_meta_ff;
    reg aw_got_ff;
    reg w_got_ff;
    reg [11:0] awaddr_ff;
    reg [31:0] wdata_ff;
    reg [3:0] wstrb_ff;

    wire int_primary = (mode_ff == M_INT1) || (mode_ff == M_INT2); // RQ18
    wire mult_freq_ok = (freq_sel_ff == `FREQ_8M) || (freq_sel_ff == `FREQ_4M); // RQ19
    wire mult_allowed = int_primary && mult_freq_ok; // RQ9
    wire clkout_active = (mode_ff == M_EXTCLK) || (mode_ff == M_RESCAP) || (mode_ff == M_INT1);

    // Write channel: address and data may arrive in either order
    wire do_write = aw_got_ff && w_got_ff && !s_axi_bvalid;
    assign s_axi_awready = !aw_got_ff && !s_axi_bvalid;
    assign s_axi_wready = !w_got_ff && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_got_ff <= 1'b0;
            w_got_ff <= 1'b0;
            awaddr_ff <= 12'h000;
            wdata_ff <= 32'h0000_0000;
            wstrb_ff <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `RESP_OKAY;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_ff <= 1'b1;
                awaddr_ff <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_ff <= 1'b1;
                wdata_ff <= s_axi_wdata;
                wstrb_ff <= s_axi_wstrb;
            end
            if (do_write) begin
                aw_got_ff <= 1'b0;
                w_got_ff <= 1'b0;
                s_axi_bvalid <= 1'b1;
                case (awaddr_ff)
                    `ADDR_CONFIG, `ADDR_CONTROL, `ADDR_TUNING, `ADDR_STATUS:
                        s_axi_bresp <= `RESP_OKAY;
                    default: s_axi_bresp <= `RESP_SLVERR;
                endcase
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Register state; the mode is decoded from the configuration on every clock
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            cfg_ff <= `CFG_RESET;
            feature_en_ff <= `FEAT_RESET;
            freq_sel_ff <= `FREQ_RESET;
            lowf_src_ff <= 1'b0;
            mult_bit_ff <= 1'b0;
            trim_ff <= 5'h00;
            mode_ff <= M_RESCAP_IO;
        end else begin
            mode_ff <= decode_mode(cfg_ff); // RQ22
            // Only the low byte strobe gates writes, including the feature bits in byte one
            if (do_write && wstrb_ff[0]) begin
                if (awaddr_ff == `ADDR_CONFIG) begin
                    cfg_ff <= wdata_ff[`CFG_CODE_MSB:0];
                    feature_en_ff <= wdata_ff[`FEAT_MSB:`FEAT_LSB];
                end
                if (awaddr_ff == `ADDR_CONTROL)
                    freq_sel_ff <= wdata_ff[`CTL_FREQ_MSB:`CTL_FREQ_LSB];
                if (awaddr_ff == `ADDR_TUNING) begin
                    lowf_src_ff <= wdata_ff[`TUN_LOWSRC_BIT];
                    trim_ff <= wdata_ff[`TUN_TRIM_MSB:0];
                end
            end
            // Bit held clear and writes dropped unless both conditions hold
            if (!mult_allowed)
                mult_bit_ff <= 1'b0; // RQ7 RQ19
            else if (do_write && wstrb_ff[0] && awaddr_ff == `ADDR_TUNING)
                mult_bit_ff <= wdata_ff[`TUN_MULT_BIT]; // RQ9
        end
    end

    // Read channel
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `RESP_OKAY;
            case (s_axi_araddr)
                `ADDR_CONFIG: s_axi_rdata <= {20'h00000, feature_en_ff, 4'h0, cfg_ff};
                `ADDR_CONTROL: s_axi_rdata <= {25'h0000000, freq_sel_ff, 4'h0};
                `ADDR_TUNING: s_axi_rdata <= {24'h000000, lowf_src_ff, mult_bit_ff,
                    1'b0, trim_ff};
                `ADDR_STATUS: s_axi_rdata <= {20'h00000, core_src_sel_ff, mode_ff,
                    main_osc_en_ff, lowf_osc_en_ff, xtal_mult_en_ff, int_mult_en_ff};
                default: begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // Source select and oscillator enables
    reg [3:0] nxt_src;
    reg nxt_main_en;
    reg nxt_lowf_en;
    always @* begin
        nxt_src = {1'b0, `SRC_EXT};
        nxt_main_en = 1'b0;
        nxt_lowf_en = 1'b0;
        if (mode_ff == M_HSM)
            nxt_src = {1'b0, `SRC_MULT}; // RQ6
        if (int_primary) begin
            // Gated by the permission too, so the source never outlives a cleared bit
            if (mult_bit_ff && mult_allowed)
                nxt_src = {1'b0, `SRC_MULT}; // RQ21
            else if (freq_sel_ff == `FREQ_8M)
                nxt_src = {1'b0, `SRC_MAIN}; // RQ10 RQ14
            else if (freq_sel_ff == `FREQ_31K)
                nxt_src = lowf_src_ff ? {1'b0, `SRC_DIV256} : {1'b0, `SRC_LOWF}; // RQ20
            else
                nxt_src = {1'b0, `SRC_POST}; // RQ14
            nxt_main_en = (freq_sel_ff != `FREQ_31K) || lowf_src_ff; // RQ11
            nxt_lowf_en = (freq_sel_ff == `FREQ_31K) && !lowf_src_ff; // RQ12
        end
        if (feature_en_ff != 4'h0)
            nxt_lowf_en = 1'b1; // RQ13
    end

    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            core_src_sel_ff <= 4'h0;
            main_osc_en_ff <= 1'b0;
            lowf_osc_en_ff <= 1'b1;
            xtal_mult_en_ff <= 1'b0;
            int_mult_en_ff <= 1'b0;
            startup_delay_en_ff <= 1'b1;
            port_a_bit_six_en_ff <= 1'b0;
            port_a_bit_seven_en_ff <= 1'b0;
        end else begin
            core_src_sel_ff <= nxt_src;
            main_osc_en_ff <= nxt_main_en;
            lowf_osc_en_ff <= nxt_lowf_en;
            xtal_mult_en_ff <= (mode_ff == M_HSM); // RQ6 RQ8
            int_mult_en_ff <= mult_bit_ff && mult_allowed; // RQ21
            // Crystal-type modes need oscillator settling; external clock does not
            startup_delay_en_ff <= (mode_ff == M_LP) || (mode_ff == M_XT) ||
                (mode_ff == M_FXTAL) || (mode_ff == M_HSM); // RQ1 RQ17
            port_a_bit_six_en_ff <= (mode_ff == M_EXTCLK_IO) || (mode_ff == M_RESCAP_IO) ||
                (mode_ff == M_INT2); // RQ3 RQ5 RQ16 RQ23
            port_a_bit_seven_en_ff <= int_primary; // RQ15 RQ16 RQ23
        end
    end

    // Clock-out: clock input pin sampled through two flops, divided by four
    // Fast core clocks alias in the sampler; the divided output is a slow-clock aid only
    always @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            clk_sync_ff <= 2'b00;
            clk_prev_ff <= 1'b0;
            quarter_ff <= 2'b00;
            clock_out_pin_o <= 1'b0;
            clock_out_pin_oe <= 1'b0;
            pa6_meta_ff <= 2'b00;
            pa7_meta_ff <= 2'b00;
            port_a_bit_six_sync_ff <= 1'b0;
            port_a_bit_seven_sync_ff <= 1'b0;
        end else begin
            clk_sync_ff <= {clk_sync_ff[0], ext_clk_in};
            clk_prev_ff <= clk_sync_ff[1];
            if (clk_sync_ff[1] && !clk_prev_ff)
                quarter_ff <= quarter_ff + 2'b01;
            clock_out_pin_o <= clkout_active & quarter_ff[1]; // RQ2 RQ4 RQ15
            clock_out_pin_oe <= clkout_active; // RQ2 RQ4 RQ15
            // Disabled pins read as zero so the port never sees clock activity
            pa6_meta_ff <= {pa6_meta_ff[0], port_a_bit_six_in};
            pa7_meta_ff <= {pa7_meta_ff[0], port_a_bit_seven_in};
            port_a_bit_six_sync_ff <= pa6_meta_ff[1] & port_a_bit_six_en_ff; // RQ23
            port_a_bit_seven_sync_ff <= pa7_meta_ff[1] & port_a_bit_seven_en_ff; // RQ23
        end
    end

endmodule // osc_mode_select

// ---- verif/ext_clock_source.sv ----
// Model of the external clock source that drives the clock input pin
`timescale 1ns/1ps

module ext_clock_source #(
    parameter HALF_NS = 730
) (
    input wire run,
    output reg clk
);
    // Kept slow against sys_clk, because the block samples this pin
    initial clk = 1'b0;
    always #(HALF_NS) clk = run ? ~clk : 1'b0;
endmodule // ext_clock_source

// ---- verif/osc_select_props.sv ----
// Concurrent checks on the ports of the oscillator mode select block
`timescale 1ns/1ps
`include "osc_select_defines.vh"

module osc_select_props (
    input wire sys_clk,
    input wire rst,
    input wire clock_out_pin_oe,
    input wire [3:0] core_src_sel_ff,
    input wire main_osc_en_ff,
    input wire lowf_osc_en_ff,
    input wire xtal_mult_en_ff,
    input wire int_mult_en_ff,
    input wire port_a_bit_six_en_ff,
    input wire port_a_bit_seven_en_ff,
    input wire port_a_bit_six_sync_ff,
    input wire port_a_bit_seven_sync_ff
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    oe_six_a: assert property (clock_out_pin_oe |-> !port_a_bit_six_en_ff)
        else $error("clock out driven while bit six is I/O");
    six_quiet_a: assert property (!port_a_bit_six_en_ff [*2] |-> !port_a_bit_six_sync_ff)
        else $error("bit six input seen while disabled");
    seven_quiet_a: assert property (
        !port_a_bit_seven_en_ff [*2] |-> !port_a_bit_seven_sync_ff)
        else $error("bit seven input seen while disabled");
    mult_excl_a: assert property (xtal_mult_en_ff |-> !int_mult_en_ff)
        else $error("software multiplier on in crystal multiplied mode");
    xmult_src_a: assert property (
        xtal_mult_en_ff |-> core_src_sel_ff == `SRC_MULT && !clock_out_pin_oe)
        else $error("crystal multiplier not driving the core");
    imult_src_a: assert property (
        int_mult_en_ff |-> core_src_sel_ff == `SRC_MULT && main_osc_en_ff)
        else $error("internal multiplier without main oscillator");
    mult_cause_a: assert property (
        core_src_sel_ff == `SRC_MULT |-> xtal_mult_en_ff || int_mult_en_ff)
        else $error("multiplier source selected with no multiplier on");
    lowf_src_a: assert property (
        core_src_sel_ff == `SRC_LOWF |-> lowf_osc_en_ff && !main_osc_en_ff)
        else $error("low frequency source selected but not running");
    main_src_a: assert property (
        core_src_sel_ff inside {`SRC_MAIN, `SRC_POST, `SRC_DIV256} |-> main_osc_en_ff)
        else $error("main oscillator off while it feeds the core");

    cover property ($rose(int_mult_en_ff));
    cover property (xtal_mult_en_ff);
    cover property (core_src_sel_ff == `SRC_DIV256);
endmodule // osc_select_props

bind osc_mode_select osc_select_props osc_select_props_inst (.sys_clk, .rst, .clock_out_pin_oe,
    .core_src_sel_ff, .main_osc_en_ff, .lowf_osc_en_ff, .xtal_mult_en_ff, .int_mult_en_ff,
    .port_a_bit_six_en_ff, .port_a_bit_seven_en_ff, .port_a_bit_six_sync_ff,
    .port_a_bit_seven_sync_ff);

// ---- verif/osc_mode_select_tb_top.sv ----
// Register-driven testbench for the oscillator mode select block
`timescale 1ns/1ps
`include "osc_select_defines.vh"

module osc_mode_select_tb_top;
    reg sys_clk = 1'b0, rst = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
    reg [11:0] awa = 12'h000, ara = 12'h000;
    reg [31:0] wd = 32'h0000_0000, rd;
    reg [15:0] e;
    reg [1:0] resp;
    reg cnt_on = 1'b0;
    reg pin_lvl = 1'b1;
    wire awr, wr_r, bv, arr, rv, ext_clk, co, coe, me, le, xm, im, sd, y6, y7, s6, s7;
    wire [1:0] br, rr;
    wire [31:0] rdat;
    wire [3:0] src;
    integer errors = 0, n_compared = 0, i, j, ne, no;
    // Per mode: code, mode index, {oe, six, seven, crystal mult}, source
    localparam [127:0] TBL = 128'h2200_8762_96a2_6315_7540_3480_5940_4880;

    initial forever #50 sys_clk = ~sys_clk;
    always @(posedge ext_clk) if (cnt_on) ne = ne + 1;
    always @(posedge co) if (cnt_on) no = no + 1;

    ext_clock_source ext_clock_source_inst (.run(1'b1), .clk(ext_clk));
    osc_mode_select osc_mode_select_inst (.sys_clk(sys_clk), .rst(rst), .s_axi_awaddr(awa),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wv), .s_axi_wready(wr_r), .s_axi_bresp(br), .s_axi_bvalid(bv),
        .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_rdata(rdat), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
        .ext_clk_in(ext_clk), .port_a_bit_six_in(pin_lvl), .port_a_bit_seven_in(pin_lvl),
        .clock_out_pin_o(co), .clock_out_pin_oe(coe), .core_src_sel_ff(src),
        .main_osc_en_ff(me), .lowf_osc_en_ff(le), .xtal_mult_en_ff(xm), .int_mult_en_ff(im),
        .startup_delay_en_ff(sd), .port_a_bit_six_en_ff(y6), .port_a_bit_seven_en_ff(y7),
        .port_a_bit_six_sync_ff(s6), .port_a_bit_seven_sync_ff(s7));

    task print_verdict;
        begin
            $display("compared %0d errors %0d", n_compared, errors);
            if (errors == 0 && n_compared > 0) $display("bench passed");
            else $display("bench failed");
            $finish;
        end
    endtask

    task check(input string nm, input [31:0] seen, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                errors = errors + 1;
                $display("Error %s expected %h seen %h", nm, exp, seen);
            end
        end
    endtask

    // Ready is combinational, so it is judged at the falling edge before the taking edge
    task wr(input [11:0] a, input [31:0] d);
        reg pa, pw, pb;
        integer k;
        begin
            @(posedge sys_clk);
            awa <= a;
            wd <= d;
            awv <= 1'b1;
            wv <= 1'b1;
            bry <= 1'b1;
            pa = 1'b1;
            pw = 1'b1;
            pb = 1'b1;
            for (k = 0; k < 40 && pb; k = k + 1) begin
                @(negedge sys_clk);
                if (awr) pa = 1'b0;
                if (wr_r) pw = 1'b0;
                if (bv) begin
                    pb = 1'b0;
                    resp = br;
                end
                @(posedge sys_clk);
                awv <= pa;
                wv <= pw;
                bry <= pb;
            end
            if (pb) begin
                errors = errors + 1;
                print_verdict;
            end
        end
    endtask

    task rdr(input [11:0] a);
        reg pa, pr;
        integer k;
        begin
            @(posedge sys_clk);
            ara <= a;
            arv <= 1'b1;
            rry <= 1'b1;
            pa = 1'b1;
            pr = 1'b1;
            for (k = 0; k < 40 && pr; k = k + 1) begin
                @(negedge sys_clk);
                if (arr) pa = 1'b0;
                if (rv) begin
                    pr = 1'b0;
                    rd = rdat;
                    resp = rr;
                end
                @(posedge sys_clk);
                arv <= pa;
                rry <= pr;
            end
            if (pr) begin
                errors = errors + 1;
                print_verdict;
            end
        end
    endtask

    task st;
        begin
            repeat (4) @(posedge sys_clk);
            @(negedge sys_clk);
        end
    endtask

    // Control before tuning, since a multiplier write is dropped unless already allowed
    task cfg(input [31:0] c, input [31:0] f, input [31:0] t);
        begin
            wr(`ADDR_CONFIG, c);
            wr(`ADDR_CONTROL, f << `CTL_FREQ_LSB);
            wr(`ADDR_TUNING, t);
            st;
        end
    endtask

    initial begin
        repeat (20) @(posedge sys_clk);
        rst <= 1'b0;
        rdr(`ADDR_CONFIG);
        check("config reset", rd, {28'h0, `CFG_RESET});
        rdr(`ADDR_CONTROL);
        check("control reset", rd, `CTL_RESET);
        rdr(`ADDR_TUNING);
        check("tuning reset", rd, 32'h0);
        rdr(12'h010);
        check("unmapped resp", resp, `RESP_SLVERR);
        check("unmapped data", rd, 32'h0);
        for (i = 0; i < 8; i = i + 1) begin
            e = TBL[i * 16 +: 16];
            wr(`ADDR_CONFIG, e[15:12]);
            check("write resp", resp, `RESP_OKAY);
            st;
            check("pins", {coe, y6, y7, xm}, e[7:4]);
            check("pin inputs", {s6, s7}, e[6:5]);
            check("source", src, e[3:0]);
            rdr(`ADDR_STATUS);
            check("mode", rd[7:4], e[11:8]);
            check("startup delay", sd, i == 4 || i == 7);
        end
        for (j = 0; j < 2; j = j + 1) begin
            wr(`ADDR_CONFIG, j ? `CFG_RESCAP : `CFG_EXTCLK);
            st;
            ne = 0;
            no = 0;
            cnt_on = 1'b1;
            repeat (1200) @(posedge sys_clk);
            cnt_on = 1'b0;
            check("clkout rate", no * 4 + 4 >= ne && no * 4 <= ne + 4 && ne > 40, 1);
        end
        for (i = 0; i < 2; i = i + 1) begin
            for (j = 4; j < 8; j = j + 1) begin
                cfg(i ? `CFG_INT_DUAL_IO : `CFG_INT_CLKOUT, j, 32'h40);
                rdr(`ADDR_TUNING);
                check("mult bit", rd[6], j > 5);
                check("int mult", im, j > 5);
                check("mult source", src, j > 5 ? `SRC_MULT : `SRC_POST);
            end
        end
        wr(`ADDR_CONTROL, 32'h50);
        st;
        rdr(`ADDR_TUNING);
        check("mult cleared", {rd[6], im}, 2'b00);
        cfg(`CFG_FXTAL_MULT, 7, 32'h40);
        rdr(`ADDR_TUNING);
        check("mult locked", {rd[6], im, xm}, 3'b001);
        cfg(`CFG_INT_DUAL_IO, 0, 32'h80);
        check("div256", {src, me}, {`SRC_DIV256, 1'b1});
        cfg(`CFG_INT_DUAL_IO, 0, 32'h00);
        check("lowf direct", {src, me, le}, {`SRC_LOWF, 2'b01});
        @(posedge sys_clk);
        pin_lvl <= 1'b0;
        st;
        check("pins low", {s6, s7}, 2'b00);
        cfg(`CFG_INT_DUAL_IO, 3, 32'h00);
        check("postscaler", {src, me}, {`SRC_POST, 1'b1});
        cfg(`CFG_INT_DUAL_IO, 7, 32'h2f);
        check("main direct", {src, me, le}, {`SRC_MAIN, 2'b10});
        rdr(`ADDR_TUNING);
        check("trim", rd, 32'h0f);
        for (j = 0; j < 4; j = j + 1) begin
            cfg((32'h100 << j) | `CFG_INT_DUAL_IO, 7, 32'h00);
            check("feature lowf", le, 1'b1);
        end
        print_verdict;
    end
endmodule // osc_mode_select_tb_top
